// *** hdl/sbh_map.vh ***
`ifndef SBH_MAP_VH
`define SBH_MAP_VH
// Opcodes of a stored or host command word
`define SBH_OP_NOP 5'h00
`define SBH_OP_LABEL 5'h01
`define SBH_OP_END 5'h02
`define SBH_OP_JMP 5'h03
`define SBH_OP_IEQ 5'h04
`define SBH_OP_INE 5'h05
`define SBH_OP_ILT 5'h06
`define SBH_OP_IGT 5'h07
`define SBH_OP_ILE 5'h08
`define SBH_OP_IGE 5'h09
`define SBH_OP_JBS 5'h0a
`define SBH_OP_JBC 5'h0b
`define SBH_OP_HALT_IMM 5'h0c
`define SBH_OP_HALT_BRK 5'h0d
`define SBH_OP_HALT_OFF 5'h0e
`define SBH_OP_CLX 5'h0f
`define SBH_OP_ACC 5'h10
`define SBH_OP_VAR 5'h11
// Arithmetic and logic function codes
`define SBH_FN_SET 4'h0
`define SBH_FN_ADD 4'h1
`define SBH_FN_SUB 4'h2
`define SBH_FN_MUL 4'h3
`define SBH_FN_DIV 4'h4
`define SBH_FN_NOT 4'h5
`define SBH_FN_AND 4'h6
`define SBH_FN_OR 4'h7
`define SBH_FN_ANDN 4'h8
`define SBH_FN_ORN 4'h9
`define SBH_FN_SHR 4'ha
`define SBH_FN_SHL 4'hb
// Register classes
`define SBH_RC_IMM 3'h0
`define SBH_RC_PARAM 3'h1
`define SBH_RC_FLOAT 3'h2
`define SBH_RC_USER 3'h3
`define SBH_RC_MONITOR 3'h4
// Command word fields: op[63:59] fn[58:55] dcls[54:52] didx[51:44] tgt[43:32] val[31:0], scls is val[31:29]
`define SBH_F_OP_HI 63
`define SBH_F_OP_LO 59
`define SBH_F_FN_HI 58
`define SBH_F_FN_LO 55
`define SBH_F_CLS_HI 54
`define SBH_F_CLS_LO 52
`define SBH_F_IDX_HI 51
`define SBH_F_IDX_LO 44
`define SBH_F_TGT_HI 43
`define SBH_F_TGT_LO 32
`define SBH_F_VAL_HI 31
`define SBH_F_VAL_LO 0
// Halt kinds on the motion side
`define SBH_HK_IMM 2'h1
`define SBH_HK_BRAKE 2'h2
`define SBH_HK_OFF 2'h3
// Sizes
`define SBH_LINES_TWO_AXIS 8190
`define SBH_LINES_PER_AXIS 4095
`endif

// *** hdl/sbh_alu.v ***
`timescale 1ns/100ps
`default_nettype none
// Combinational accumulator arithmetic and logic unit
module sbh_alu (
	// Operands
	input wire [3:0] fn,
	input wire signed [31:0] opA,
	input wire signed [31:0] opB,
	// Result
	output reg signed [31:0] result,
	output reg fnValid
);
`include "sbh_map.vh"

	wire signed [63:0] prod = opA * opB;
	wire [4:0] amt = opB[4:0];

	// Wraps to 32 bits; quotient truncates toward zero, divide by zero keeps opA
	always @* begin
		result = opA;
		fnValid = 1'b1;
		case (fn)
			`SBH_FN_SET: result = opB;
			`SBH_FN_ADD: result = opA + opB;
			`SBH_FN_SUB: result = opA - opB;
			`SBH_FN_MUL: result = prod[31:0];
			`SBH_FN_DIV: result = (opB == 32'sh0) ? opA : opA / opB;
			`SBH_FN_NOT: result = ~opB;
			`SBH_FN_AND: result = opA & opB;
			`SBH_FN_OR: result = opA | opB;
			`SBH_FN_ANDN: result = opA & ~opB;
			`SBH_FN_ORN: result = opA | ~opB;
			`SBH_FN_SHR: result = opA >>> amt;
			`SBH_FN_SHL: result = opA << amt;
			default: fnValid = 1'b0;
		endcase
	end
endmodule // sbh_alu
`default_nettype wire

// *** hdl/sbh_engine.v ***
`timescale 1ns/100ps
`default_nettype none
`include "sbh_map.vh"
module sbh_engine #(
	parameter LINES = `SBH_LINES_TWO_AXIS,
	parameter AW = 13,
	parameter NAXES = 32,
	parameter NVARS = 256
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Host command port
	input wire cmdValid,
	input wire [63:0] cmdWord,
	input wire [NAXES-1:0] cmdAxes,
	output reg cmdReady,
	output reg cmdReject,
	// Sequence store write port
	input wire storeWe,
	input wire [AW-1:0] storeAddr,
	input wire [63:0] storeData,
	input wire [AW-1:0] storeLen,
	// External register address, read replies and writes for parameters and floats
	output reg [2:0] extCls,
	output reg [7:0] extIdx,
	input wire signed [31:0] extData,
	output reg extWe,
	output reg signed [31:0] extWdata,
	// Motion side
	output reg [NAXES-1:0] haltAxes,
	output reg [1:0] haltKind,
	output reg haltStrobe,
	output reg [NAXES-1:0] motorPowerEnable,
	// Status
	output reg running,
	output reg [AW-1:0] pc,
	output reg signed [31:0] accumulator
);

	localparam ST_IDLE = 3'h0;
	localparam ST_FETCH = 3'h1;
	localparam ST_EXEC = 3'h2;
	localparam ST_SEARCH = 3'h3;
	localparam ST_CLEAR = 3'h4;

	// Stored sequence and user variables; sized by parameter for both variants
	reg [63:0] seqMem [0:LINES-1];
	reg signed [31:0] userVar [0:NVARS-1];

	reg [2:0] state;
	reg [63:0] ir;
	reg fromHost;
	reg [11:0] target;
	reg [AW-1:0] scan;
	reg [AW-1:0] scanCount;
	reg [8:0] clrIdx;
	reg [NAXES-1:0] curAxes;

	wire [4:0] op = ir[`SBH_F_OP_HI:`SBH_F_OP_LO];
	wire [3:0] fn = ir[`SBH_F_FN_HI:`SBH_F_FN_LO];
	wire [2:0] cls = ir[`SBH_F_CLS_HI:`SBH_F_CLS_LO];
	wire [7:0] idx = ir[`SBH_F_IDX_HI:`SBH_F_IDX_LO];
	wire [11:0] tgt = ir[`SBH_F_TGT_HI:`SBH_F_TGT_LO];
	wire signed [31:0] imm = ir[`SBH_F_VAL_HI:`SBH_F_VAL_LO];

	// Reference operand: immediate, user variable, or external register read now
	function [31:0] resolve;
		input [2:0] c;
		input [7:0] i;
		input [31:0] immv;
		input [31:0] uv;
		input [31:0] ext;
		begin
			case (c)
				`SBH_RC_IMM: resolve = immv;
				`SBH_RC_USER: resolve = uv;
				default: resolve = ext;
			endcase
		end
	endfunction

	// Operand class of a data operand lives in the top 3 bits of the immediate
	wire [2:0] srcCls = imm[31:29];
	wire [7:0] srcIdx = imm[7:0];
	wire signed [31:0] refVal = resolve(srcCls, srcIdx, {{3{imm[28]}}, imm[28:0]},
		userVar[srcIdx], extData);

	// Signed comparisons against the current accumulator
	wire cmpEq = (accumulator == refVal);
	wire cmpLt = (accumulator < refVal);
	wire [4:0] bitSel = refVal[4:0];
	wire bitVal = accumulator[bitSel];

	reg take;
	always @* begin
		case (op)
			`SBH_OP_IEQ: take = cmpEq;
			`SBH_OP_INE: take = !cmpEq;
			`SBH_OP_ILT: take = cmpLt;
			`SBH_OP_IGT: take = !cmpLt && !cmpEq;
			`SBH_OP_ILE: take = cmpLt || cmpEq;
			`SBH_OP_IGE: take = !cmpLt;
			`SBH_OP_JBS: take = bitVal;
			`SBH_OP_JBC: take = !bitVal;
			default: take = 1'b0;
		endcase
	end

	// Left operand is the destination's current value
	wire signed [31:0] destVal = (op == `SBH_OP_ACC) ? accumulator :
		(cls == `SBH_RC_USER) ? userVar[idx] : extData;
	wire signed [31:0] aluOut;
	wire aluOk;
	sbh_alu uAlu (
		.fn(fn),
		.opA(destVal),
		.opB(refVal),
		.result(aluOut),
		.fnValid(aluOk)
	);

	// Only parameters, floats and user variables may be operated on
	wire clsOk = (cls == `SBH_RC_PARAM) || (cls == `SBH_RC_FLOAT) || (cls == `SBH_RC_USER);

	wire [63:0] scanWord = seqMem[scan];
	wire [AW-1:0] nextPc = pc + {{(AW-1){1'b0}}, 1'b1};
	wire atLast = (nextPc >= storeLen);

	// Store writes from the host
	always @(posedge clk) begin
		if (storeWe)
			seqMem[storeAddr] <= storeData;
	end

	// External register address follows the operand being resolved
	always @* begin
		extCls = srcCls;
		extIdx = srcIdx;
		if (op == `SBH_OP_VAR && cls != `SBH_RC_USER && state == ST_EXEC) begin
			extCls = cls;
			extIdx = idx;
		end
	end

	// User variables: cleared by sweep or written by operations
	always @(posedge clk) begin
		if (state == ST_CLEAR)
			userVar[clrIdx[7:0]] <= 32'sh0;
		else if (state == ST_EXEC && op == `SBH_OP_VAR && cls == `SBH_RC_USER && aluOk)
			userVar[idx] <= aluOut;
	end

	// Main sequencer
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			ir <= 64'h0;
			fromHost <= 1'b0;
			target <= 12'h0;
			scan <= {AW{1'b0}};
			scanCount <= {AW{1'b0}};
			clrIdx <= 9'h0;
			curAxes <= {NAXES{1'b0}};
			cmdReady <= 1'b0;
			cmdReject <= 1'b0;
			extWe <= 1'b0;
			extWdata <= 32'sh0;
			haltAxes <= {NAXES{1'b0}};
			haltKind <= 2'h0;
			haltStrobe <= 1'b0;
			motorPowerEnable <= {NAXES{1'b1}};
			running <= 1'b0;
			pc <= {AW{1'b0}};
			accumulator <= 32'sh0;
		end else begin
			cmdReady <= 1'b0;
			cmdReject <= 1'b0;
			haltStrobe <= 1'b0;
			extWe <= 1'b0;
			// Host commands are taken when idle, and halts are taken at any time
			if (cmdValid && (state == ST_IDLE ||
				cmdWord[`SBH_F_OP_HI:`SBH_F_OP_LO] == `SBH_OP_HALT_IMM ||
				cmdWord[`SBH_F_OP_HI:`SBH_F_OP_LO] == `SBH_OP_HALT_BRK ||
				cmdWord[`SBH_F_OP_HI:`SBH_F_OP_LO] == `SBH_OP_HALT_OFF)) begin
				ir <= cmdWord;
				curAxes <= cmdAxes;
				fromHost <= 1'b1;
				cmdReady <= 1'b1;
				state <= ST_EXEC;
			end else begin
				case (state)
					ST_IDLE: running <= 1'b0;
					ST_FETCH: begin
						ir <= seqMem[pc];
						fromHost <= 1'b0;
						state <= ST_EXEC;
					end
					ST_EXEC: begin
						// Default: step to the next line or stop after the last
						state <= fromHost ? ST_IDLE : (atLast ? ST_IDLE : ST_FETCH);
						if (!fromHost) begin
							pc <= nextPc;
							if (atLast)
								running <= 1'b0;
						end
						case (op)
							`SBH_OP_END: begin
								running <= 1'b0;
								state <= ST_IDLE;
							end
							`SBH_OP_JMP: begin
								target <= tgt;
								scan <= {AW{1'b0}};
								scanCount <= {AW{1'b0}};
								running <= 1'b1;
								state <= ST_SEARCH;
							end
							`SBH_OP_IEQ, `SBH_OP_INE, `SBH_OP_ILT, `SBH_OP_IGT,
							`SBH_OP_ILE, `SBH_OP_IGE, `SBH_OP_JBS, `SBH_OP_JBC: begin
								if (take) begin
									target <= tgt;
									scan <= {AW{1'b0}};
									scanCount <= {AW{1'b0}};
									running <= 1'b1;
									state <= ST_SEARCH;
								end
							end
							`SBH_OP_HALT_IMM, `SBH_OP_HALT_BRK, `SBH_OP_HALT_OFF: begin
								haltAxes <= fromHost ? curAxes : {NAXES{1'b1}};
								haltStrobe <= 1'b1;
								running <= 1'b0;
								state <= ST_IDLE;
								if (op == `SBH_OP_HALT_IMM)
									haltKind <= `SBH_HK_IMM;
								else if (op == `SBH_OP_HALT_BRK)
									haltKind <= `SBH_HK_BRAKE;
								else begin
									haltKind <= `SBH_HK_OFF;
									motorPowerEnable <= motorPowerEnable &
										~(fromHost ? curAxes : {NAXES{1'b1}});
								end
							end
							`SBH_OP_CLX: begin
								accumulator <= 32'sh0;
								clrIdx <= 9'h0;
								state <= ST_CLEAR;
							end
							`SBH_OP_ACC: begin
								if (aluOk)
									accumulator <= aluOut;
								else if (fromHost)
									cmdReject <= 1'b1;
							end
							`SBH_OP_VAR: begin
								if (!clsOk || !aluOk) begin
									if (fromHost)
										cmdReject <= 1'b1;
								end else if (cls != `SBH_RC_USER) begin
									extWe <= 1'b1;
									extWdata <= aluOut;
								end
							end
							`SBH_OP_NOP, `SBH_OP_LABEL: ;
							default: if (fromHost) cmdReject <= 1'b1;
						endcase
					end
					ST_SEARCH: begin
						// Linear scan for the label line; resume on the line after it
						if (scanWord[`SBH_F_OP_HI:`SBH_F_OP_LO] == `SBH_OP_LABEL &&
							scanWord[`SBH_F_TGT_HI:`SBH_F_TGT_LO] == target) begin
							pc <= scan + {{(AW-1){1'b0}}, 1'b1};
							state <= (scan + {{(AW-1){1'b0}}, 1'b1} >= storeLen) ? ST_IDLE : ST_FETCH;
						end else if (scanCount + {{(AW-1){1'b0}}, 1'b1} >= storeLen) begin
							running <= 1'b0;
							state <= ST_IDLE;
						end else begin
							scan <= scan + {{(AW-1){1'b0}}, 1'b1};
							scanCount <= scanCount + {{(AW-1){1'b0}}, 1'b1};
						end
					end
					ST_CLEAR: begin
						clrIdx <= clrIdx + 9'h1;
						if (clrIdx[7:0] == 8'hff)
							state <= fromHost ? ST_IDLE : ST_FETCH;
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // sbh_engine
`default_nettype wire

// *** dv/sbh_engine_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sbh_map.vh"
module sbh_engine_monitor #(
	parameter NAXES = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host side
	input wire logic cmdValid,
	input wire logic [63:0] cmdWord,
	input wire logic [NAXES-1:0] cmdAxes,
	input wire logic cmdReady,
	input wire logic cmdReject,
	// Motion side and status
	input wire logic [NAXES-1:0] haltAxes,
	input wire logic [1:0] haltKind,
	input wire logic haltStrobe,
	input wire logic [NAXES-1:0] motorPowerEnable,
	input wire logic running,
	input wire logic signed [31:0] accumulator
);
	logic [4:0] op;
	logic isHalt;
	// Decode only what the checks need
	assign op = cmdWord[63:59];
	assign isHalt = (op == `SBH_OP_HALT_IMM) || (op == `SBH_OP_HALT_BRK) || (op == `SBH_OP_HALT_OFF);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Halts are taken even mid-sequence and drop running two cycles on
	chk_halt_taken: assert property (cmdValid && isHalt |=> cmdReady ##1 (haltStrobe && !running))
		else $error("halt not applied in time");
	chk_halt_idle: assert property (haltStrobe |-> !running [*3])
		else $error("engine restarted after halt");
	chk_halt_imm: assert property (cmdValid && op == `SBH_OP_HALT_IMM |-> ##2 haltKind == `SBH_HK_IMM)
		else $error("wrong kind for immediate halt");
	chk_halt_brake: assert property (cmdValid && op == `SBH_OP_HALT_BRK |-> ##2 haltKind == `SBH_HK_BRAKE)
		else $error("wrong kind for braked halt");
	chk_halt_power: assert property (cmdValid && op == `SBH_OP_HALT_OFF |-> ##2
		(haltKind == `SBH_HK_OFF && (motorPowerEnable & $past(cmdAxes, 2)) == '0))
		else $error("power not removed on halted axes");
	chk_power_kept: assert property (haltStrobe && haltKind != `SBH_HK_OFF |-> $stable(motorPowerEnable))
		else $error("power changed by a plain halt");
	chk_halt_axes: assert property (cmdValid && isHalt |-> ##2 haltAxes == $past(cmdAxes, 2))
		else $error("halt axes differ from mask");
	chk_clear_acc: assert property (cmdValid && !running && op == `SBH_OP_CLX |-> ##[2:300] accumulator == 0)
		else $error("accumulator not cleared");
	chk_class_reject: assert property (cmdValid && !running && op == `SBH_OP_VAR
		&& cmdWord[54:52] == `SBH_RC_MONITOR |-> ##2 cmdReject)
		else $error("bad register class accepted");
endmodule // sbh_engine_monitor
`default_nettype wire

// *** dv/sbh_ext_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sbh_map.vh"
module sbh_ext_model (
	// Clock
	input wire logic clk,
	// Register access from the engine
	input wire logic [2:0] extCls,
	input wire logic [7:0] extIdx,
	input wire logic extWe,
	input wire logic [31:0] extWdata,
	// Read data
	output logic [31:0] extData
);
	logic [31:0] regs [0:511];
	logic [8:0] lastAddr;
	logic [31:0] junk;
	// Parameters in the low half, floats in the high half
	initial begin
		junk = 32'h5a5a_a5a5;
		for (int i = 0; i < 512; i++)
			regs[i] = 32'h0001_0000 + i;
	end
	// Other classes read a changing pattern so a stray use cannot pass by luck
	always_comb begin
		if (extCls == `SBH_RC_PARAM || extCls == `SBH_RC_FLOAT)
			extData = regs[{extCls[1], extIdx}];
		else
			extData = junk;
	end
	// Writes land on the address of the previous cycle
	always @(posedge clk) begin
		junk <= ~junk;
		lastAddr <= {extCls[1], extIdx};
		if (extWe)
			regs[lastAddr] <= extWdata;
	end
endmodule // sbh_ext_model
`default_nettype wire

// *** dv/sbh_testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sbh_map.vh"
module testbench;
	logic clk, rst_n, cmdValid, storeWe, cmdReady, cmdReject, extWe, haltStrobe, running;
	logic [63:0] cmdWord, storeData;
	logic [31:0] cmdAxes, extData, extWdata, haltAxes, motorPowerEnable, accumulator;
	logic [12:0] storeAddr, storeLen, pc;
	logic [2:0] extCls;
	logic [7:0] extIdx;
	logic [1:0] haltKind;
	logic [63:0] prog [0:7];
	int errors, cmp_count;
	sbh_engine i_dut (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdAxes(cmdAxes),
		.cmdReady(cmdReady), .cmdReject(cmdReject), .storeWe(storeWe), .storeAddr(storeAddr),
		.storeData(storeData), .storeLen(storeLen), .extCls(extCls), .extIdx(extIdx), .extData(extData),
		.extWe(extWe), .extWdata(extWdata), .haltAxes(haltAxes), .haltKind(haltKind),
		.haltStrobe(haltStrobe), .motorPowerEnable(motorPowerEnable), .running(running), .pc(pc),
		.accumulator(accumulator));
	sbh_ext_model i_ext (.clk(clk), .extCls(extCls), .extIdx(extIdx), .extWe(extWe),
		.extWdata(extWdata), .extData(extData));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [63:0] cw(input logic [4:0] op, input logic [3:0] fn, input logic [11:0] tgt,
		input logic [31:0] v);
		cw = {op, fn, 3'h0, 8'h0, tgt, v};
	endfunction
	// Immediates carry class zero in the top three bits
	function automatic logic [31:0] imm(input logic [31:0] v);
		imm = {3'h0, v[28:0]};
	endfunction
	task automatic test_done;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bounded wait for running to reach a level
	task automatic wait_run(input logic lvl);
		int n;
		n = 0;
		while (running !== lvl) begin
			@(posedge clk);
			n++;
			if (n > 3000) begin
				errors++;
				test_done();
			end
		end
	endtask
	// Command is taken on its one valid edge; ready follows
	task automatic send(input logic [63:0] w, input logic [31:0] ax);
		int n;
		n = 0;
		cmdWord <= w;
		cmdAxes <= ax;
		cmdValid <= 1'b1;
		@(posedge clk);
		cmdValid <= 1'b0;
		do begin
			@(posedge clk);
			n++;
			if (n > 8) begin
				errors++;
				test_done();
			end
		end while (cmdReady !== 1'b1);
	endtask
	task automatic load(input int a, input int n);
		for (int i = a; i < a + n; i++) begin
			storeWe <= 1'b1;
			storeAddr <= i[12:0];
			storeData <= prog[i];
			@(posedge clk);
		end
		storeWe <= 1'b0;
	endtask
	// Every test kind against acc -3; skipped path leaves marker 1, branch leaves 2
	task automatic t_branch;
		logic [4:0] ops [0:8];
		logic [31:0] refs [0:8];
		logic [8:0] tk;
		ops = '{`SBH_OP_IEQ, `SBH_OP_INE, `SBH_OP_ILT, `SBH_OP_IGT, `SBH_OP_ILE, `SBH_OP_IGE,
			`SBH_OP_JBS, `SBH_OP_JBS, `SBH_OP_JBC};
		refs = '{-3, -3, 2, 2, -3, 2, 31, 1, 1};
		tk = 9'h155;
		for (int i = 0; i < 9; i++) begin
			prog[1] = cw(ops[i], 4'h0, 12'h2, imm(refs[i]));
			load(1, 1);
			send(cw(`SBH_OP_ACC, `SBH_FN_SET, 12'h0, imm(-3)), '0);
			send(cw(`SBH_OP_JMP, 4'h0, 12'h1, 32'h0), '0);
			repeat (2) @(posedge clk);
			wait_run(1'b0);
			chk(accumulator, tk[i] ? 32'h2 : 32'h1);
			chk({19'h0, pc}, tk[i] ? 32'h6 : 32'h4);
		end
	endtask
	// Host operations chained on the accumulator, last one reads a parameter
	task automatic t_alu;
		logic [3:0] fns [0:9];
		logic [31:0] vals [0:9];
		logic [31:0] exps [0:9];
		fns = '{`SBH_FN_SET, `SBH_FN_SHL, `SBH_FN_SHR, `SBH_FN_DIV, `SBH_FN_SUB, `SBH_FN_SHR,
			`SBH_FN_MUL, `SBH_FN_SET, `SBH_FN_ANDN, `SBH_FN_SET};
		vals = '{23, 3, 2, 7, 50, 1, 3, 43, 18, 32'h2000_0003};
		exps = '{23, 184, 46, 6, -44, -22, -66, 43, 41, 32'h0001_0003};
		for (int i = 0; i < 10; i++) begin
			send(cw(`SBH_OP_ACC, fns[i], 12'h0, vals[i]), '0);
			repeat (2) @(posedge clk);
			chk(accumulator, exps[i]);
		end
	endtask
	task automatic t_reject;
		logic [63:0] w;
		logic seen;
		w = cw(`SBH_OP_VAR, `SBH_FN_SET, 12'h0, 32'h1);
		w[54:52] = `SBH_RC_MONITOR;
		seen = 1'b0;
		cmdWord <= w;
		cmdValid <= 1'b1;
		@(posedge clk);
		cmdValid <= 1'b0;
		repeat (4) begin
			@(posedge clk);
			seen = seen | cmdReject;
		end
		chk({31'h0, seen}, 32'h1);
	endtask
	// Each halt kind hits a looping sequence
	task automatic t_halt;
		logic [4:0] hop [0:2];
		logic [31:0] ax [0:2];
		hop = '{`SBH_OP_HALT_IMM, `SBH_OP_HALT_BRK, `SBH_OP_HALT_OFF};
		ax = '{32'h12, 32'h4000_0086, 32'h12};
		storeLen <= 13'd8;
		for (int k = 0; k < 3; k++) begin
			send(cw(`SBH_OP_JMP, 4'h0, 12'h3, 32'h0), '0);
			wait_run(1'b1);
			send(cw(hop[k], 4'h0, 12'h0, 32'h0), ax[k]);
			@(posedge clk);
			chk({31'h0, haltStrobe}, 32'h1);
			chk({30'h0, haltKind}, k + 1);
			chk(haltAxes, ax[k]);
			chk(motorPowerEnable, (k == 2) ? ~32'h12 : 32'hffff_ffff);
			chk({31'h0, running}, 32'h0);
		end
	endtask
	// User variable and parameter writes, read back through the accumulator
	task automatic t_var;
		logic [63:0] w;
		w = cw(`SBH_OP_VAR, `SBH_FN_SET, 12'h0, 32'h7);
		w[54:52] = `SBH_RC_USER;
		w[51:44] = 8'h05;
		send(w, '0);
		send(cw(`SBH_OP_ACC, `SBH_FN_SET, 12'h0, 32'h6000_0005), '0);
		repeat (2) @(posedge clk);
		chk(accumulator, 32'h7);
		w = cw(`SBH_OP_VAR, `SBH_FN_SET, 12'h0, 32'h9);
		w[54:52] = `SBH_RC_PARAM;
		w[51:44] = 8'h04;
		send(w, '0);
		@(posedge clk);
		chk({31'h0, extWe}, 32'h1);
		chk(extWdata, 32'h9);
		send(cw(`SBH_OP_ACC, `SBH_FN_SET, 12'h0, 32'h2000_0004), '0);
		repeat (2) @(posedge clk);
		chk(accumulator, 32'h9);
	endtask
	task automatic t_clx;
		send(cw(`SBH_OP_ACC, `SBH_FN_SET, 12'h0, 32'h7), '0);
		send(cw(`SBH_OP_CLX, 4'h0, 12'h0, 32'h0), '0);
		repeat (260) @(posedge clk);
		chk(accumulator, 32'h0);
		send(cw(`SBH_OP_ACC, `SBH_FN_SET, 12'h0, 32'h6000_0005), '0);
		repeat (2) @(posedge clk);
		chk(accumulator, 32'h0);
	endtask
	// Main sequence
	initial begin
		rst_n = 1'b0;
		cmdValid = 1'b0;
		cmdWord = '0;
		cmdAxes = '0;
		storeWe = 1'b0;
		storeAddr = '0;
		storeData = '0;
		storeLen = 13'd6;
		prog = '{cw(`SBH_OP_LABEL, 4'h0, 12'h1, 32'h0), cw(`SBH_OP_NOP, 4'h0, 12'h0, 32'h0),
			cw(`SBH_OP_ACC, `SBH_FN_SET, 12'h0, 32'h1), cw(`SBH_OP_END, 4'h0, 12'h0, 32'h0),
			cw(`SBH_OP_LABEL, 4'h0, 12'h2, 32'h0), cw(`SBH_OP_ACC, `SBH_FN_SET, 12'h0, 32'h2),
			cw(`SBH_OP_LABEL, 4'h0, 12'h3, 32'h0), cw(`SBH_OP_JMP, 4'h0, 12'h3, 32'h0)};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		load(0, 8);
		t_branch();
		t_alu();
		t_reject();
		t_halt();
		t_var();
		t_clx();
		test_done();
	end
endmodule // testbench
bind sbh_engine sbh_engine_monitor #(.NAXES(NAXES)) i_mon (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
	.cmdWord(cmdWord), .cmdAxes(cmdAxes), .cmdReady(cmdReady), .cmdReject(cmdReject), .haltAxes(haltAxes),
	.haltKind(haltKind), .haltStrobe(haltStrobe), .motorPowerEnable(motorPowerEnable), .running(running),
	.accumulator(accumulator));
`default_nettype wire
